/* File: hdl/msa_arbiter.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - The steal enable goes only to the requester chosen by fixed priority among the active requests.
// - There are four requests, numbered one to four, with one highest and four lowest in priority.
// - An active request blocks every lower-priority request from being granted.
// - Any active request stalls the processor, and the stall lasts until no request is active.
// - The I/O control and the processor share one wired-OR address bus, so only one side drives it at a time.
// - While an I/O control holds steal enable the processor's address drive is switched off.
// - On a steal read the processor read-data bus is cut off and memory data goes to the steal read-data bus.
module msa_arbiter #(
  parameter int unsigned NUM_REQ = msa_pkg::NUM_REQ,
  parameter int unsigned ADDR_W = msa_pkg::ADDR_W,
  parameter int unsigned DATA_W = msa_pkg::DATA_W,
  parameter int unsigned FIFO_DEPTH = msa_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [NUM_REQ-1:0] steal_request,
  input wire logic [ADDR_W-1:0] cpu_address,
  input wire logic cpu_write_n,
  input wire logic [DATA_W-1:0] main_memory_data,
  input wire logic [ADDR_W-1:0] io_address,
  input wire logic io_write_n,
  input wire logic [DATA_W-1:0] external_input_bus,
  input wire logic io_read_ready,
  output logic [NUM_REQ-1:0] steal_enable,
  output logic processor_stall,
  output logic [ADDR_W-1:0] shared_memory_address,
  output logic cpu_address_drive_n,
  output logic dma_memory_write_n,
  output logic [DATA_W-1:0] memory_write_data,
  output logic [DATA_W-1:0] cpu_read_data,
  output logic steal_read_valid,
  output logic [DATA_W-1:0] memory_read_data_bus,
  output logic steal_read_overflow
);
  ////////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    msa_pkg::msa_state_t state;
    logic [NUM_REQ-1:0] grant;
    logic stall;
    logic [ADDR_W-1:0] addr;
    logic addr_drive_n;
    logic write_n;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] cpu_rdata;
    logic overflow;
  } msa_arb_t;

  msa_arb_t s;
  msa_arb_t next_s;
  logic [NUM_REQ-1:0] req;
  logic [NUM_REQ-1:0] pick;
  logic read_cycle;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic fifo_out_ready;
  logic read_taken;

  // Requests come from other cards on their own timing, so they are synchronised first.
  msa_sync #(.WIDTH(NUM_REQ)) u_req_sync (
    .clock(clock),
    .nrst(nrst),
    .din(steal_request),
    .dout(req)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Fixed priority: bit 0 is request one, the highest.
  always_comb begin
    pick = '0;
    for (int i = NUM_REQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick = '0;
        pick[i] = 1'b1;
      end
    end
  end

  // A read cycle is one granted with the write strobe idle.
  assign read_cycle = (s.state == msa_pkg::MSA_STEAL) && io_write_n;

  always_comb begin
    next_s = s;
    next_s.stall = |req;
    case (s.state)
      msa_pkg::MSA_IDLE: begin
        next_s.grant = pick;
        if (|req) begin
          next_s.state = msa_pkg::MSA_STEAL;
        end
      end
      msa_pkg::MSA_STEAL: begin
        // A higher request preempts at the next clock; the grant follows the request each cycle.
        next_s.grant = pick;
        if (!(|req)) begin
          next_s.state = msa_pkg::MSA_IDLE;
        end
      end
      default: begin
        next_s.state = msa_pkg::MSA_IDLE;
        next_s.grant = '0;
      end
    endcase
    if (|next_s.grant) begin
      next_s.addr = io_address;
      next_s.addr_drive_n = 1'b1;
      next_s.write_n = io_write_n;
      next_s.wdata = external_input_bus;
    end else begin
      next_s.addr = cpu_address;
      next_s.addr_drive_n = 1'b0;
      next_s.write_n = 1'b1;
      next_s.wdata = '0;
    end
    // The processor read path is frozen during a read steal so it never sees stolen data.
    if (!read_cycle) begin
      next_s.cpu_rdata = main_memory_data;
    end
    // Losing a stolen word is reported rather than silently stalling memory.
    if (read_cycle && !fifo_in_ready) begin
      next_s.overflow = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s <= '0;
      s.state <= msa_pkg::MSA_IDLE;
      s.grant <= msa_pkg::GRANT_RESET;
      s.stall <= msa_pkg::STALL_RESET;
      s.write_n <= msa_pkg::WRITE_N_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stolen read data waits here until the I/O control takes it.
  msa_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_read_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(read_cycle),
    .in_ready(fifo_in_ready),
    .in_data(main_memory_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } msa_out_t;

  msa_out_t o;
  msa_out_t next_o;

  // The output register is a pipeline stage with a valid bit of its own, and a word leaves it only at an edge
  // where the I/O control sees it valid and raises ready. Copying the buffer head blindly would hand out a
  // stale word, or the same word twice, whenever ready stays high.
  always_comb begin
    read_taken = o.valid && io_read_ready;
    fifo_out_ready = !o.valid || read_taken;
    next_o = o;
    if (fifo_out_ready) begin
      next_o.valid = fifo_out_valid;
      next_o.data = fifo_out_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  assign steal_enable = s.grant;
  assign processor_stall = s.stall;
  assign shared_memory_address = s.addr;
  assign cpu_address_drive_n = s.addr_drive_n;
  assign dma_memory_write_n = s.write_n;
  assign memory_write_data = s.wdata;
  assign cpu_read_data = s.cpu_rdata;
  assign steal_read_valid = o.valid;
  assign memory_read_data_bus = o.data;
  assign steal_read_overflow = s.overflow;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_grant_onehot: assert property (@(posedge clock) disable iff (!nrst) $onehot0(steal_enable))
    else $error("more than one steal enable");
  a_grant_top: assert property (@(posedge clock) disable iff (!nrst) req[0] |=> steal_enable[0])
    else $error("request one not granted");
  a_grant_block: assert property (@(posedge clock) disable iff (!nrst)
    (|req[1:0]) |=> !steal_enable[3])
    else $error("lowest request granted over higher");
  a_grant_pick: assert property (@(posedge clock) disable iff (!nrst) 1'b1 |=> steal_enable == $past(pick))
    else $error("grant differs from priority pick");
  a_stall_hold: assert property (@(posedge clock) disable iff (!nrst)
    (|req) |=> processor_stall ##0 (steal_enable != '0 || !$past(|req)))
    else $error("stall missing during request");
  a_stall_end: assert property (@(posedge clock) disable iff (!nrst) !(|req) |=> !processor_stall)
    else $error("stall outlasts requests");
  a_grant_drop: assert property (@(posedge clock) disable iff (!nrst)
    (steal_enable[1] && !req[1]) |=> !steal_enable[1])
    else $error("grant held after request ended");
  a_addr_off: assert property (@(posedge clock) disable iff (!nrst)
    (|steal_enable) |-> cpu_address_drive_n)
    else $error("processor drives address during steal");
  a_addr_owner: assert property (@(posedge clock) disable iff (!nrst)
    !(|steal_enable) |-> (!cpu_address_drive_n && dma_memory_write_n))
    else $error("address bus owner mismatch");
  a_read_freeze: assert property (@(posedge clock) disable iff (!nrst)
    read_cycle |=> $stable(cpu_read_data))
    else $error("processor read data changed during steal read");

  ////////////////////////////////////////////////////////////////////////////////
  // Every grant check looks one register stage behind the synchronised requests.
  a_grant_second: assert property (@(posedge clock) disable iff (!nrst)
    (req[1] && !req[0]) |=> steal_enable[1])
    else $error("request two not granted while top");
  a_grant_third: assert property (@(posedge clock) disable iff (!nrst)
    (req[2] && !(|req[1:0])) |=> steal_enable[2])
    else $error("request three not granted while top");
  a_grant_fourth: assert property (@(posedge clock) disable iff (!nrst)
    (req[3] && !(|req[2:0])) |=> steal_enable[3])
    else $error("request four not granted while alone");
  a_block_second: assert property (@(posedge clock) disable iff (!nrst)
    req[0] |=> !steal_enable[1])
    else $error("request two granted over request one");
  a_block_third: assert property (@(posedge clock) disable iff (!nrst)
    (|req[1:0]) |=> !steal_enable[2])
    else $error("request three granted over a higher one");
  a_block_fourth: assert property (@(posedge clock) disable iff (!nrst)
    (|req[2:0]) |=> !steal_enable[3])
    else $error("request four granted over a higher one");
  a_grant_requested: assert property (@(posedge clock) disable iff (!nrst)
    1'b1 |=> ((steal_enable & ~$past(req)) == '0))
    else $error("steal enable given to an idle requester");
  a_grant_any: assert property (@(posedge clock) disable iff (!nrst)
    (|req) |=> (|steal_enable))
    else $error("no grant while a request is active");
  a_grant_none: assert property (@(posedge clock) disable iff (!nrst)
    !(|req) |=> !(|steal_enable))
    else $error("grant stands with no request");
  a_stall_match: assert property (@(posedge clock) disable iff (!nrst)
    processor_stall == (|steal_enable))
    else $error("stall and grant disagree");
  a_stall_rise: assert property (@(posedge clock) disable iff (!nrst)
    $rose(|req) |=> $rose(processor_stall))
    else $error("stall late after first request");
  a_stall_fall: assert property (@(posedge clock) disable iff (!nrst)
    $fell(|req) |=> $fell(processor_stall))
    else $error("stall late after last request");
  a_drive_match: assert property (@(posedge clock) disable iff (!nrst)
    cpu_address_drive_n == (|steal_enable))
    else $error("processor address drive does not follow grant");
  a_addr_cpu: assert property (@(posedge clock) disable iff (!nrst)
    ($past(nrst) && !(|steal_enable)) |-> (shared_memory_address == $past(cpu_address)))
    else $error("address bus not from processor while idle");
  a_addr_steal: assert property (@(posedge clock) disable iff (!nrst)
    (|steal_enable) |-> (shared_memory_address == $past(io_address)))
    else $error("address bus not from I/O control during steal");
  a_wdata_idle: assert property (@(posedge clock) disable iff (!nrst)
    !(|steal_enable) |-> (memory_write_data == '0))
    else $error("write data driven while idle");
  a_wdata_steal: assert property (@(posedge clock) disable iff (!nrst)
    (|steal_enable) |-> (memory_write_data == $past(external_input_bus)))
    else $error("write data not from I/O control during steal");
  a_write_steal: assert property (@(posedge clock) disable iff (!nrst)
    (|steal_enable) |-> (dma_memory_write_n == $past(io_write_n)))
    else $error("write strobe not from I/O control during steal");
  a_cpu_follow: assert property (@(posedge clock) disable iff (!nrst)
    !read_cycle |=> (cpu_read_data == $past(main_memory_data)))
    else $error("processor read data frozen outside a steal read");
  a_ovf_sticky: assert property (@(posedge clock) disable iff (!nrst)
    steal_read_overflow |=> steal_read_overflow)
    else $error("overflow flag cleared without reset");
  a_ovf_set: assert property (@(posedge clock) disable iff (!nrst)
    (read_cycle && !fifo_in_ready) |=> steal_read_overflow)
    else $error("lost read word not flagged");
  a_out_hold: assert property (@(posedge clock) disable iff (!nrst)
    (steal_read_valid && !io_read_ready) |=> (steal_read_valid && $stable(memory_read_data_bus)))
    else $error("steal read word changed before it was taken");
  a_out_fill: assert property (@(posedge clock) disable iff (!nrst)
    (fifo_out_valid && !steal_read_valid) |=> steal_read_valid)
    else $error("buffered word not offered");
  a_out_drain: assert property (@(posedge clock) disable iff (!nrst)
    (steal_read_valid && io_read_ready && !fifo_out_valid) |=> !steal_read_valid)
    else $error("steal read valid held after last word");
endmodule : msa_arbiter

/* File: hdl/msa_pkg.sv */
package msa_pkg;
  localparam int unsigned NUM_REQ = 4;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [3:0] GRANT_RESET = 4'h0;
  localparam logic STALL_RESET = 1'b0;
  localparam logic WRITE_N_RESET = 1'b1;

  typedef enum logic [1:0] {
    MSA_IDLE,
    MSA_STEAL
  } msa_state_t;
endpackage : msa_pkg

/* File: hdl/msa_sync.sv */
`timescale 1ns/1ps
module msa_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } msa_sync_t;

  msa_sync_t s;
  msa_sync_t next_s;

  // The first stage feeds only the second one, so a metastable sample never reaches logic.
  always_comb begin
    next_s.meta = din;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.stable;
endmodule : msa_sync

/* File: hdl/msa_fifo.sv */
`timescale 1ns/1ps
module msa_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } msa_fifo_t;

  msa_fifo_t s;
  msa_fifo_t next_s;
  logic push;
  logic pop;

  always_comb begin
    push = in_valid && (s.count != (AW+1)'(DEPTH));
    pop = out_ready && (s.count != '0);
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + AW'(1);
    end
    if (pop) begin
      next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + AW'(1);
    end
    next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready = (s.count != (AW+1)'(DEPTH));
  assign out_valid = (s.count != '0);
  assign out_data = s.mem[s.rd];
endmodule : msa_fifo

/* File: verification/msa_io_model.sv */
`timescale 1ns/1ps
module msa_io_model #(
  parameter logic [15:0] ADDR = 16'h0a5c,
  parameter logic [15:0] WDATA = 16'hc3e1
) (
  input wire logic clock,
  input wire logic [3:0] want,
  input wire logic write_mode,
  input wire logic pop,
  input wire logic [3:0] steal_enable,
  input wire logic steal_read_valid,
  input wire logic [15:0] memory_read_data_bus,
  output logic [3:0] steal_request,
  output logic [15:0] io_address,
  output logic io_write_n,
  output logic [15:0] external_input_bus,
  output logic io_read_ready,
  output logic [15:0] taken_word
);
  logic granted;
  logic [15:0] churn = 16'h5a5a;
  assign granted = |steal_enable;
  assign steal_request = want;
  // Released lines change every cycle, so a stale value never passes for a driven one.
  always @(posedge clock) churn <= ~churn;
  assign io_address = granted ? ADDR : churn;
  assign io_write_n = ~(granted & write_mode);
  assign external_input_bus = (granted & write_mode) ? WDATA : churn;
  assign io_read_ready = pop;
  always @(posedge clock) if (pop && steal_read_valid) taken_word <= memory_read_data_bus;
endmodule : msa_io_model

/* File: verification/tb_memory_steal_arbiter.sv */
`timescale 1ns/1ps
module tb_memory_steal_arbiter;
  localparam logic [15:0] IO_ADDR = 16'h0a5c;
  localparam logic [15:0] IO_DATA = 16'hc3e1;
  localparam logic [15:0] CPU_ADDR = 16'h7e10;
  // The output register holds one word beyond the buffer's depth.
  localparam int HELD = msa_pkg::FIFO_DEPTH + 1;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] want = 4'h0;
  logic write_mode = 1'b0;
  logic pop = 1'b0;
  logic [15:0] main_memory_data = 16'h0000;
  logic [3:0] steal_request, steal_enable;
  logic [15:0] io_address, external_input_bus, shared_memory_address, memory_write_data;
  logic [15:0] cpu_read_data, memory_read_data_bus, taken_word;
  logic io_write_n, io_read_ready, processor_stall, cpu_address_drive_n;
  logic dma_memory_write_n, steal_read_valid, steal_read_overflow;
  int n_errors = 0;
  int compares = 0;
  always #5 clock = ~clock;
  // Memory data counts up each cycle so words taken by the far side reveal their order.
  always @(posedge clock) main_memory_data <= #1 main_memory_data + 16'h0001;
  msa_arbiter u_msa_arbiter (.clock(clock), .nrst(nrst), .steal_request(steal_request),
    .cpu_address(CPU_ADDR), .cpu_write_n(1'b1), .main_memory_data(main_memory_data),
    .io_address(io_address), .io_write_n(io_write_n), .external_input_bus(external_input_bus),
    .io_read_ready(io_read_ready), .steal_enable(steal_enable), .processor_stall(processor_stall),
    .shared_memory_address(shared_memory_address), .cpu_address_drive_n(cpu_address_drive_n),
    .dma_memory_write_n(dma_memory_write_n), .memory_write_data(memory_write_data),
    .cpu_read_data(cpu_read_data), .steal_read_valid(steal_read_valid),
    .memory_read_data_bus(memory_read_data_bus), .steal_read_overflow(steal_read_overflow));
  msa_io_model #(.ADDR(IO_ADDR), .WDATA(IO_DATA)) u_msa_io_model (.clock(clock), .want(want),
    .write_mode(write_mode), .pop(pop), .steal_enable(steal_enable),
    .steal_read_valid(steal_read_valid), .memory_read_data_bus(memory_read_data_bus),
    .steal_request(steal_request), .io_address(io_address), .io_write_n(io_write_n),
    .external_input_bus(external_input_bus), .io_read_ready(io_read_ready), .taken_word(taken_word));
////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
////////////////////////////////////////////////////////////////////////////////
  task automatic idle_state;
    chk({12'h000, steal_enable}, 16'h0000);
    chk({15'h0000, processor_stall}, 16'h0000);
    chk({15'h0000, cpu_address_drive_n}, 16'h0000);
    chk({15'h0000, dma_memory_write_n}, 16'h0001);
    chk(shared_memory_address, CPU_ADDR);
  endtask : idle_state
  // Requests rise lowest first so each new one must take the grant away from the last.
  task automatic priority_order;
    for (int i = 3; i >= 0; i--) begin
      want[i] = 1'b1;
      // The far side drives its address only once it sees the grant, so the bus is judged one cycle later.
      cyc(4);
      chk({12'h000, steal_enable}, 16'h0001 << i);
      chk({15'h0000, processor_stall}, 16'h0001);
      chk({15'h0000, cpu_address_drive_n}, 16'h0001);
      chk(shared_memory_address, IO_ADDR);
    end
    for (int i = 0; i < 3; i++) begin
      want[i] = 1'b0;
      cyc(3);
      chk({12'h000, steal_enable}, 16'h0002 << i);
      chk({15'h0000, processor_stall}, 16'h0001);
    end
    want = 4'h0;
    cyc(3);
    idle_state();
  endtask : priority_order
  task automatic steal_write;
    write_mode = 1'b1;
    want = 4'h4;
    cyc(5);
    chk({12'h000, steal_enable}, 16'h0004);
    chk({15'h0000, dma_memory_write_n}, 16'h0000);
    chk(memory_write_data, IO_DATA);
    want = 4'h0;
    cyc(4);
    chk(memory_write_data, 16'h0000);
    idle_state();
    write_mode = 1'b0;
  endtask : steal_write
  // A mid-run reset empties the buffer, a long read burst then outruns it, and the far side drains it
  // back to back, so every word it holds must leave exactly once and in memory order.
  task automatic steal_read;
    logic [15:0] prev;
    logic [15:0] frozen;
    nrst = 1'b0;
    cyc(3);
    nrst = 1'b1;
    cyc(1);
    chk({15'h0000, steal_read_valid}, 16'h0000);
    chk({15'h0000, steal_read_overflow}, 16'h0000);
    idle_state();
    want = 4'h1;
    cyc(10);
    frozen = cpu_read_data;
    chk({15'h0000, dma_memory_write_n}, 16'h0001);
    cyc(10);
    chk(cpu_read_data, frozen);
    want = 4'h0;
    cyc(4);
    chk({15'h0000, steal_read_overflow}, 16'h0001);
    // Memory data counted on through the 21 cycles for which the processor path stood frozen.
    chk(cpu_read_data, frozen + 16'h0015);
    for (int j = 0; j < 10 && steal_read_valid !== 1'b1; j++) cyc(1);
    pop = 1'b1;
    for (int k = 0; k < HELD; k++) begin
      chk({15'h0000, steal_read_valid}, 16'h0001);
      cyc(1);
      if (k > 0) chk(taken_word, prev + 16'h0001);
      prev = taken_word;
    end
    pop = 1'b0;
    chk({15'h0000, steal_read_valid}, 16'h0000);
  endtask : steal_read
////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge clock);
    n_errors++;
    results();
  end
  initial begin
    cyc(5);
    nrst = 1'b1;
    cyc(1);
    idle_state();
    priority_order();
    steal_write();
    steal_read();
    results();
  end
endmodule : tb_memory_steal_arbiter
